// ===== fpt_map.vh
// Purpose: constants for the flash parameter table lookup, dwords 3 to 9
// Assumes: byte offsets are relative to the table start at 1120h
// Notes: one fixed byte per offset
// Operation
// RULE1: table first byte sits at address 1120h
// RULE2: offset 08h returns 44h, quad io cycles
// RULE3: offset 09h returns quad io opcode EBh
// RULE4: offset 0Ah returns 08h, quad out cycles
// RULE5: offset 0Bh returns quad out opcode 6Bh
// RULE6: dual out unsupported: 0Ch 00h, 0Dh FFh
// RULE7: dual io unsupported: 0Eh 00h, 0Fh FFh
// RULE8: offset 10h returns EEh, no quad command mode
// RULE9: reserved offsets 11h-15h, 18h-19h return FFh
// RULE10: all-dual unsupported: 16h 00h, 17h FFh
// RULE11: quad command mode unsupported: 1Ah 00h, 1Bh FFh
// RULE12: erase types 1,2 absent: size 00h, opcode FFh
// RULE13: erase type 3: size 13h, opcode D8h
// RULE14: erase type 4 absent: 22h 00h, 23h FFh
// RULE15: one fixed byte per offset, no other influence
`ifndef FPT_MAP_VH
`define FPT_MAP_VH
`define FPT_BASE_ADDR 16'h1120
`define FPT_FIRST_OFS 8'h08
`define FPT_LAST_OFS 8'h23
`define FPT_QIO_CYC 8'h44
`define FPT_QIO_OP 8'hEB
`define FPT_QOUT_CYC 8'h08
`define FPT_QOUT_OP 8'h6B
`define FPT_NONE_CYC 8'h00
`define FPT_NONE_OP 8'hFF
`define FPT_MODES 8'hEE
`define FPT_RESV 8'hFF
`define FPT_ER3_SIZE 8'h13
`define FPT_ER3_OP 8'hD8
`define FPT_OUT_RST 8'hFF
`define FPT_QIO_MODE_CYC 3'h2
`define FPT_QIO_DUMMY_CYC 5'h04
`define FPT_QOUT_MODE_CYC 3'h0
`define FPT_QOUT_DUMMY_CYC 5'h08
`define FPT_NONE_MODE_CYC 3'h0
`define FPT_NONE_DUMMY_CYC 5'h00
`define FPT_RESV_FIELD 3'h7
`define FPT_QCMD_BIT 1'h0
`define FPT_ALL_DUAL_BIT 1'h0
`define FPT_ER_ABSENT 8'h00
`endif

// ===== fpt_rom.v
// Purpose: fixed byte lookup of basic flash parameter table dwords 3 to 9
// Assumes: addr is an absolute parameter-space address from same-clock logic
// Notes: data registered one cycle after addr; outside the range reads FFh
`timescale 1ns/100ps
`default_nettype none
`include "fpt_map.vh"
module fpt_rom (
  input wire ref_clk,
  input wire rst_n,
  input wire [15:0] addr,
  output wire [7:0] rd_data,
  output wire hit
);

  // table geometry
  localparam ENTRY_COUNT = 28;
  localparam IDX_W = 5;
  localparam TABLE_W = 8 * ENTRY_COUNT;

  // fixed byte for one relative offset, built from its fields
  function [7:0] fpt_entry_byte;
    input [7:0] ofs_in;
    reg [2:0] mode_cyc;
    reg [4:0] dummy_cyc;
    begin
      fpt_entry_byte = `FPT_OUT_RST;
      mode_cyc = 3'h0;
      dummy_cyc = 5'h00;
      case (ofs_in)
        8'h08: begin
          mode_cyc = `FPT_QIO_MODE_CYC; // see RULE2
          dummy_cyc = `FPT_QIO_DUMMY_CYC; // see RULE2
          fpt_entry_byte = {mode_cyc, dummy_cyc};
        end

        8'h09: begin
          fpt_entry_byte = `FPT_QIO_OP; // see RULE3
        end

        8'h0A: begin
          mode_cyc = `FPT_QOUT_MODE_CYC; // see RULE4
          dummy_cyc = `FPT_QOUT_DUMMY_CYC; // see RULE4
          fpt_entry_byte = {mode_cyc, dummy_cyc};
        end

        8'h0B: begin
          fpt_entry_byte = `FPT_QOUT_OP; // see RULE5
        end

        8'h0C: begin
          mode_cyc = `FPT_NONE_MODE_CYC; // see RULE6
          dummy_cyc = `FPT_NONE_DUMMY_CYC; // see RULE6
          fpt_entry_byte = {mode_cyc, dummy_cyc};
        end

        8'h0D: begin
          fpt_entry_byte = `FPT_NONE_OP; // see RULE6
        end

        8'h0E: begin
          mode_cyc = `FPT_NONE_MODE_CYC; // see RULE7
          dummy_cyc = `FPT_NONE_DUMMY_CYC; // see RULE7
          fpt_entry_byte = {mode_cyc, dummy_cyc};
        end

        8'h0F: begin
          fpt_entry_byte = `FPT_NONE_OP; // see RULE7
        end

        8'h10: begin
          fpt_entry_byte = {`FPT_RESV_FIELD, `FPT_QCMD_BIT, // see RULE8
            `FPT_RESV_FIELD, `FPT_ALL_DUAL_BIT};
        end

        8'h11: begin
          fpt_entry_byte = `FPT_RESV; // see RULE9
        end

        8'h12: begin
          fpt_entry_byte = `FPT_RESV; // see RULE9
        end

        8'h13: begin
          fpt_entry_byte = `FPT_RESV; // see RULE9
        end

        8'h14: begin
          fpt_entry_byte = `FPT_RESV; // see RULE9
        end

        8'h15: begin
          fpt_entry_byte = `FPT_RESV; // see RULE9
        end

        8'h16: begin
          mode_cyc = `FPT_NONE_MODE_CYC; // see RULE10
          dummy_cyc = `FPT_NONE_DUMMY_CYC; // see RULE10
          fpt_entry_byte = {mode_cyc, dummy_cyc};
        end

        8'h17: begin
          fpt_entry_byte = `FPT_NONE_OP; // see RULE10
        end

        8'h18: begin
          fpt_entry_byte = `FPT_RESV; // see RULE9
        end

        8'h19: begin
          fpt_entry_byte = `FPT_RESV; // see RULE9
        end

        8'h1A: begin
          mode_cyc = `FPT_NONE_MODE_CYC; // see RULE11
          dummy_cyc = `FPT_NONE_DUMMY_CYC; // see RULE11
          fpt_entry_byte = {mode_cyc, dummy_cyc};
        end

        8'h1B: begin
          fpt_entry_byte = `FPT_NONE_OP; // see RULE11
        end

        8'h1C: begin
          fpt_entry_byte = `FPT_ER_ABSENT; // see RULE12
        end

        8'h1D: begin
          fpt_entry_byte = `FPT_NONE_OP; // see RULE12
        end

        8'h1E: begin
          fpt_entry_byte = `FPT_ER_ABSENT; // see RULE12
        end

        8'h1F: begin
          fpt_entry_byte = `FPT_NONE_OP; // see RULE12
        end

        8'h20: begin
          fpt_entry_byte = `FPT_ER3_SIZE; // see RULE13
        end

        8'h21: begin
          fpt_entry_byte = `FPT_ER3_OP; // see RULE13
        end

        8'h22: begin
          fpt_entry_byte = `FPT_ER_ABSENT; // see RULE14
        end

        8'h23: begin
          fpt_entry_byte = `FPT_NONE_OP; // see RULE14
        end

        default: begin
          fpt_entry_byte = `FPT_OUT_RST;
        end
      endcase
    end
  endfunction

  // constant table, entry 0 holds offset 08h
  wire [TABLE_W-1:0] table_flat;
  genvar k;

  generate
    for (k = 0; k < ENTRY_COUNT; k = k + 1) begin : g_entry
      localparam [31:0] ENTRY_OFS = k + `FPT_FIRST_OFS;
      assign table_flat[8*k +: 8] = fpt_entry_byte(ENTRY_OFS[7:0]); // see RULE15
    end
  endgenerate

  // relative offset and range check
  wire [15:0] rel_addr;
  wire above_base;
  wire rel_page_zero;
  wire [7:0] rel_ofs;
  wire ofs_low_ok;
  wire ofs_high_ok;
  wire in_table;
  wire [7:0] idx_full;
  wire [IDX_W-1:0] entry_idx;

  assign rel_addr = addr - `FPT_BASE_ADDR; // see RULE1
  assign above_base = (addr >= `FPT_BASE_ADDR); // see RULE1
  assign rel_page_zero = (rel_addr[15:8] == 8'h00);
  assign rel_ofs = rel_addr[7:0];
  assign ofs_low_ok = (rel_ofs >= `FPT_FIRST_OFS);
  assign ofs_high_ok = (rel_ofs <= `FPT_LAST_OFS);
  assign in_table = above_base && rel_page_zero && ofs_low_ok && ofs_high_ok;
  assign idx_full = rel_ofs - `FPT_FIRST_OFS;
  assign entry_idx = in_table ? idx_full[IDX_W-1:0] : {IDX_W{1'h0}};

  // lookup of the addressed entry
  reg [7:0] data_reg;
  reg [7:0] data_next;
  reg hit_reg;
  reg hit_next;

  always @* begin
    hit_next = 1'h0;
    data_next = `FPT_OUT_RST;
    if (in_table) begin
      hit_next = 1'h1;
      data_next = table_flat[8*entry_idx +: 8]; // see RULE15
    end
  end

  // output stage, one cycle after the address
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      data_reg <= `FPT_OUT_RST;
    end else begin
      data_reg <= data_next; // see RULE15
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      hit_reg <= 1'h0;
    end else begin
      hit_reg <= hit_next;
    end
  end

  assign rd_data = data_reg;
  assign hit = hit_reg;
endmodule // fpt_rom
`default_nettype wire

// ===== fpt_rom_checker.sv
// Purpose: port checks. Assumes: one cycle latency. Notes: none
`timescale 1ns/100ps
`default_nettype none
module fpt_rom_checker(input wire ref_clk,input wire rst_n,input wire [15:0] addr,
  input wire [7:0] rd_data,input wire hit);
  logic rst_q = 1'b0;
  always @(posedge ref_clk) rst_q <= rst_n;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !rst_q);
  a_qio_cyc: assert property (addr==16'h1128|=>rd_data==8'h44) else $error("bad");
  a_qio_op: assert property (addr==16'h1129|=>rd_data==8'hEB) else $error("bad");
  a_qout_op: assert property (addr==16'h112B|=>rd_data==8'h6B) else $error("bad");
  a_mode_bits: assert property (addr==16'h1130|=>rd_data==8'hEE) else $error("bad");
  a_resv_byte: assert property (addr inside {[16'h1131:16'h1135]}|=>rd_data==8'hFF)
    else $error("bad");
  a_er3_op: assert property (addr==16'h1141|=>rd_data==8'hD8) else $error("bad");
  a_hit_flag: assert property (addr inside {[16'h1128:16'h1143]}|=>hit)
    else $error("bad");
  a_out_range: assert property (
    !(addr inside {[16'h1128:16'h1143]})|=>!hit&&rd_data==8'hFF) else $error("bad");
  cover property (addr==16'h1141);
  cover property (!hit ##1 hit);
  cover property (hit ##1 !hit);
endmodule // fpt_rom_checker
`default_nettype wire

// ===== fpt_host.sv
// Purpose: host reader. Assumes: one cycle latency. Notes: none
`timescale 1ns/100ps
`default_nettype none
module fpt_host(input wire ref_clk,output logic [15:0] addr,input wire [7:0] rd_data);
  initial addr=16'h0000;
  task rd(input [7:0] o,output [7:0] d);
    @(posedge ref_clk) addr<=16'h1120+o;
    @(posedge ref_clk);
    @(negedge ref_clk) d=rd_data;
  endtask
endmodule // fpt_host
`default_nettype wire

// ===== fpt_rom_tb.sv
// Purpose: table bench. Assumes: host model. Notes: none
`timescale 1ns/100ps
`default_nettype none
module fpt_rom_tb;
  logic ref_clk=0,rst_n=0; wire [15:0] addr; wire [7:0] rd_data; wire hit; logic [7:0] d;
  int n_fail=0,checks_done=0;
  logic [223:0] tbl=224'h44EB086B00FF00FFEEFFFFFFFFFF00FFFFFF00FF00FF00FF13D800FF;
  always #20 ref_clk=~ref_clk;
  fpt_rom fpt_rom_i(.ref_clk(ref_clk),.rst_n(rst_n),.addr(addr),.rd_data(rd_data),.hit(hit));
  fpt_host fpt_host_i(.ref_clk(ref_clk),.addr(addr),.rd_data(rd_data));
  task chk(input [7:0] g,input [7:0] e,input h);
    checks_done++;
    if (g!==e||hit!==h) begin n_fail++; $display("Error %0t %h %h",$time,{hit,g},{h,e}); end
  endtask
  task t_table; for (int i=0;i<28;i++) begin fpt_host_i.rd(8'(i+8),d);
    chk(d,tbl[223-8*i-:8],1'b1); end endtask
  task t_out; fpt_host_i.rd(8'h07,d); chk(d,8'hFF,1'b0); fpt_host_i.rd(8'h24,d);
    chk(d,8'hFF,1'b0); endtask
  task t_reset; @(posedge ref_clk) rst_n<=1'b0;
    fpt_host_i.rd(8'h09,d); chk(d,8'hFF,1'b0);
    @(posedge ref_clk) rst_n<=1'b1;
    fpt_host_i.rd(8'h09,d); chk(d,8'hEB,1'b1);
  endtask
  task final_report; $display("fails %0d checks %0d",n_fail,checks_done);
    if (n_fail==0&&checks_done>0) $display("Regression OK"); else $display("Regression broken");
    $finish; endtask
  initial begin #20000; n_fail++; final_report; end
  initial begin repeat (5) @(posedge ref_clk); rst_n<=1'b1; t_table; t_out; t_reset; final_report; end
endmodule // fpt_rom_tb
bind fpt_rom fpt_rom_checker fpt_rom_checker_i(.ref_clk(ref_clk),.rst_n(rst_n),.addr(addr),
  .rd_data(rd_data),.hit(hit));
`default_nettype wire
